// [hdl/adc_conversion_control.sv]
`timescale 1ns/1ps
module adc_conversion_control (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [adc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	input wire logic rcTick,
	input wire logic sleepMode,
	input wire logic compareHigh,
	output logic [adc_pkg::RESULT_BITS-1:0] trialCode,
	output logic sampleHold,
	output logic [6:0] channelConnect,
	output logic refFromPin,
	output logic tempEnable,
	output logic tempHighRange,
	output logic fixedRefEnable,
	output logic [1:0] converterRefGain,
	output logic [1:0] comparatorRefGain,
	output logic converterOn,
	output logic irqRequest,
	output logic wakeRequest,
	output logic vectorRequest
);
	import adc_pkg::*;

	// ********************************
	// decode helpers
	// ********************************

	// half bit period in system clocks for a divided source
	function automatic logic [5:0] halfPeriod(input logic [2:0] sel);
		case (sel)
			CLK_DIV2: halfPeriod = 6'h01;
			CLK_DIV4: halfPeriod = 6'h02;
			CLK_DIV8: halfPeriod = 6'h04;
			CLK_DIV16: halfPeriod = 6'h08;
			CLK_DIV32: halfPeriod = 6'h10;
			CLK_DIV64: halfPeriod = 6'h20;
			default: halfPeriod = 6'h01;
		endcase
	endfunction

	// one-hot source select; unlisted codes connect nothing
	function automatic logic [6:0] chanDecode(input logic [4:0] code);
		chanDecode = 7'h00;
		if (code <= CHAN_PIN_LAST) begin
			chanDecode[code[1:0]] = 1'b1;
		end else if (code == CHAN_TEMP) begin
			chanDecode[4] = 1'b1;
		end else if (code == CHAN_DAC) begin
			chanDecode[5] = 1'b1;
		end else if (code == CHAN_FIXED_REF) begin
			chanDecode[6] = 1'b1;
		end
	endfunction

	// ********************************
	// state
	// ********************************
	ctrl_zero_type ctrlZero;
	ctrl_one_type ctrlOne;
	fixed_ref_type fixedRef;
	state_type state;
	logic [7:0] resultHigh;
	logic [7:0] resultLow;
	logic doneFlag;
	logic doneIrqEnable;
	logic periphIrqEnable;
	logic globalIrqEnable;
	logic [5:0] divCount;
	logic [4:0] halfCount;
	logic [RESULT_BITS-1:0] approx;
	logic [RESULT_BITS-1:0] bitMask;
	logic rcSelected;
	logic halfTick;
	logic writeZero;
	logic startReq;
	logic abortReq;
	logic sleepAbort;
	logic decideNow;
	logic finishNow;
	logic [RESULT_BITS-1:0] decided;
	logic [RESULT_BITS-1:0] next_approx;

	assign rcSelected = (ctrlOne.clockSelect[1:0] == 2'b11);
	assign writeZero = regWrite && (regAddr == OFF_CTRL_ZERO);

	assign startReq = writeZero && regWrData[1] && regWrData[0] && (state == IDLE);
	assign abortReq = writeZero && !regWrData[1] && (state == CONVERT);

	// a divided clock stops in sleep, so the conversion is dropped
	// sleep stops non-rc conversion
	assign sleepAbort = sleepMode && !rcSelected && (state == CONVERT);

	// the rc tick runs on its own oscillator and bypasses the divider
	// bit clock source, rc tick or divided system clock
	assign halfTick = rcSelected ? rcTick : (divCount == halfPeriod(ctrlOne.clockSelect) - 6'h01);

	// bits decided on odd half periods after sampling
	assign decideNow = halfTick && (state == CONVERT) && halfCount[0]
		&& (halfCount >= 5'(FIRST_DECIDE_HALF)) && (bitMask != '0);
	assign finishNow = halfTick && (state == CONVERT)
		&& (halfCount == 5'(TAD_PER_CONV_X2 - 1));

	// ********************************
	// successive approximation
	// ********************************

	// keep bit on compare, undecided bits copy the last one
	always_comb begin
		decided = approx;
		next_approx = approx;
		if (decideNow) begin
			decided = compareHigh ? (approx | bitMask) : (approx & ~bitMask);
			next_approx = compareHigh ? (decided | (bitMask - 1'b1))
				: (decided & ~(bitMask - 1'b1));
		end
	end

	// half-period divider, runs only while converting
	// restarts on every tick so each half lasts exactly half the ratio
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			divCount <= '0;
		end else if (state != CONVERT || halfTick || rcSelected) begin
			divCount <= '0;
		end else begin
			divCount <= divCount + 6'h01;
		end
	end

	// half period counter over 23 halves
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			halfCount <= '0;
		end else if (state != CONVERT) begin
			halfCount <= '0;
		end else if (halfTick) begin
			halfCount <= halfCount + 5'h01;
		end
	end

	// conversion sequencing
	// a start asleep on a divided clock is refused, it could never end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= IDLE;
		end else begin
			case (state)
				IDLE: begin
					if (startReq && !(sleepMode && !rcSelected)) begin
						state <= CONVERT;
					end
				end
				CONVERT: begin
					if (finishNow || abortReq || sleepAbort || !ctrlZero.on) begin
						state <= IDLE;
					end
				end
				default: state <= IDLE;
			endcase
		end
	end

	// trial bit walk and working value
	// a fresh start always begins again from the top bit
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			approx <= '0;
			bitMask <= '0;
		end else if (startReq) begin
			approx <= '0;
			bitMask <= {1'b1, {(RESULT_BITS-1){1'b0}}};
		end else if (decideNow) begin
			approx <= next_approx;
			bitMask <= bitMask >> 1;
		end
	end

	// trial code and sample hold to the analog side
	// only decided bits and the bit on trial reach the dac
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			trialCode <= '0;
			sampleHold <= 1'b0;
		end else begin
			trialCode <= (approx & ~((bitMask << 1) - 1'b1)) | bitMask;
			sampleHold <= (state == CONVERT) && (halfCount >= 5'(FIRST_DECIDE_HALF));
		end
	end

	// ********************************
	// result pair
	// ********************************

	// a sleep abort keeps the last result, as does a switch-off written with the start bit set
	// justify, zero fill, also partial value on abort
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			resultHigh <= RESET_BYTE;
			resultLow <= RESET_BYTE;
		end else if (finishNow || abortReq) begin
			if (ctrlOne.justify) begin
				resultHigh <= {6'h00, decided[9:8]};
				resultLow <= decided[7:0];
			end else begin
				resultHigh <= decided[9:2];
				resultLow <= {decided[1:0], 6'h00};
			end
		end
	end

	// ********************************
	// control registers
	// ********************************

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrlZero <= ctrl_zero_type'(RESET_BYTE);
		end else begin
			if (writeZero) begin
				ctrlZero.channel <= regWrData[6:2];
				ctrlZero.on <= regWrData[0];
			end
			ctrlZero.reserved <= 1'b0;
			ctrlZero.go <= (state == CONVERT && !(finishNow || abortReq || sleepAbort
				|| !ctrlZero.on)) || (startReq && !(sleepMode && !rcSelected));
		end
	end

	// clock, justify and reference fields; unused bits read zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrlOne <= ctrl_one_type'(RESET_BYTE);
		end else if (regWrite && regAddr == OFF_CTRL_ONE) begin
			ctrlOne <= ctrl_one_type'({regWrData[7:4], 2'b00, regWrData[1:0]});
		end
	end

	// ready reads as enable
	// no settling model, the buffer counts as ready once enabled
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			fixedRef <= fixed_ref_type'(RESET_BYTE);
		end else if (regWrite && regAddr == OFF_FIXED_REF_TEMP) begin
			fixedRef <= fixed_ref_type'({regWrData[BIT_FR_ENABLE], regWrData[BIT_FR_ENABLE],
				regWrData[5:0]});
		end
	end

	// software may also write the flag high
	// flag on every completion, sticky, set beats clear
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			doneFlag <= 1'b0;
		end else if (finishNow) begin
			doneFlag <= 1'b1;
		end else if (regWrite && regAddr == OFF_IRQ_CONTROL) begin
			doneFlag <= regWrData[BIT_IRQ_FLAG];
		end
	end

	// interrupt enables, written together with the flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			doneIrqEnable <= 1'b0;
			periphIrqEnable <= 1'b0;
			globalIrqEnable <= 1'b0;
		end else if (regWrite && regAddr == OFF_IRQ_CONTROL) begin
			doneIrqEnable <= regWrData[BIT_IRQ_ENABLE];
			periphIrqEnable <= regWrData[BIT_IRQ_PERIPH];
			globalIrqEnable <= regWrData[BIT_IRQ_GLOBAL];
		end
	end

	// ********************************
	// outputs to analog and core
	// ********************************

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			channelConnect <= '0;
			refFromPin <= 1'b0;
			tempEnable <= 1'b0;
			tempHighRange <= 1'b0;
			fixedRefEnable <= 1'b0;
			converterRefGain <= '0;
			comparatorRefGain <= '0;
			converterOn <= 1'b0;
		end else begin
			channelConnect <= chanDecode(ctrlZero.channel);
			refFromPin <= (ctrlOne.posRef == PREF_PIN);
			tempEnable <= fixedRef.tempEnable;
			tempHighRange <= fixedRef.tempRange;
			fixedRefEnable <= fixedRef.fixedRefEnable;
			converterRefGain <= fixedRef.converterGain;
			comparatorRefGain <= fixedRef.comparatorGain;
			converterOn <= ctrlZero.on;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			irqRequest <= 1'b0;
			wakeRequest <= 1'b0;
			vectorRequest <= 1'b0;
		end else begin
			irqRequest <= doneFlag && doneIrqEnable;
			wakeRequest <= doneFlag && doneIrqEnable && sleepMode;
			vectorRequest <= doneFlag && doneIrqEnable && periphIrqEnable && globalIrqEnable;
		end
	end

	// read data one cycle after the strobe, unmapped reads zero
	// a read has no side effect on any flag
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= RESET_BYTE;
		end else if (regRead) begin
			case (regAddr)
				OFF_CTRL_ZERO: regRdData <= ctrlZero;
				OFF_CTRL_ONE: regRdData <= ctrlOne;
				OFF_RESULT_HIGH: regRdData <= resultHigh;
				OFF_RESULT_LOW: regRdData <= resultLow;
				OFF_FIXED_REF_TEMP: regRdData <= fixedRef;
				OFF_IRQ_CONTROL: regRdData <= {4'h0, globalIrqEnable, periphIrqEnable,
					doneIrqEnable, doneFlag};
				default: regRdData <= RESET_BYTE;
			endcase
		end else begin
			regRdData <= RESET_BYTE;
		end
	end

endmodule

// [hdl/adc_pkg.sv]
// How it works
// - sar builds ten-bit result into result pair
// - channel code connects one of seven sources
// - clock field picks divider or internal rc
// - conversion lasts eleven and half bit periods
// - done flag sets on every completion
// - done flag held until software clears
// - request needs flag and enable both set
// - enabled done request wakes sleeping core
// - no global enable means inline resume
// - all three enables set means vectoring
// - in sleep only rc clock keeps converting
// - divided clocks track the system clock
// - justify bit picks left or right placement
// - reference select picks supply or pin
// - sense enable bit powers temperature sensor
// - range bit picks high or low range
// - completion clears busy, flags, loads result
// - writing start and on bits together begins, reads busy
// - unused result bits load as zero
// - five-bit channel codes, others connect nothing
package adc_pkg;

	// ********************************
	// register map
	// ********************************
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFF_CTRL_ZERO = 3'h0;
	localparam logic [2:0] OFF_CTRL_ONE = 3'h1;
	localparam logic [2:0] OFF_RESULT_HIGH = 3'h2;
	localparam logic [2:0] OFF_RESULT_LOW = 3'h3;
	localparam logic [2:0] OFF_FIXED_REF_TEMP = 3'h4;
	localparam logic [2:0] OFF_IRQ_CONTROL = 3'h5;

	// ********************************
	// field positions and reset values
	// ********************************
	localparam int BIT_IRQ_FLAG = 0;
	localparam int BIT_IRQ_ENABLE = 1;
	localparam int BIT_IRQ_PERIPH = 2;
	localparam int BIT_IRQ_GLOBAL = 3;
	localparam int BIT_FR_ENABLE = 7;
	localparam int BIT_FR_READY = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ********************************
	// conversion timing
	// ********************************
	localparam int RESULT_BITS = 10;
	localparam int TAD_PER_CONV_X2 = 23;
	localparam int FIRST_DECIDE_HALF = 3;
	localparam int RC_TAD_MIN_NS = 1000;
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int TEMP_SETTLE_US = 200;
	localparam int TEMP_SETTLE_CYCLES = TEMP_SETTLE_US * 1000 / CLOCK_PERIOD_NS;

	// ********************************
	// codes
	// ********************************
	localparam logic [2:0] CLK_DIV2 = 3'h0;
	localparam logic [2:0] CLK_DIV4 = 3'h4;
	localparam logic [2:0] CLK_DIV8 = 3'h1;
	localparam logic [2:0] CLK_DIV16 = 3'h5;
	localparam logic [2:0] CLK_DIV32 = 3'h2;
	localparam logic [2:0] CLK_DIV64 = 3'h6;
	localparam logic [4:0] CHAN_TEMP = 5'h1d;
	localparam logic [4:0] CHAN_DAC = 5'h1e;
	localparam logic [4:0] CHAN_FIXED_REF = 5'h1f;
	localparam logic [4:0] CHAN_PIN_LAST = 5'h03;
	localparam logic [1:0] PREF_SUPPLY = 2'h0;
	localparam logic [1:0] PREF_PIN = 2'h2;

	typedef enum logic {IDLE, CONVERT} state_type;

	typedef struct packed {
		logic reserved;
		logic [4:0] channel;
		logic go;
		logic on;
	} ctrl_zero_type;

	typedef struct packed {
		logic justify;
		logic [2:0] clockSelect;
		logic [1:0] reserved;
		logic [1:0] posRef;
	} ctrl_one_type;

	typedef struct packed {
		logic fixedRefEnable;
		logic fixedRefReady;
		logic tempEnable;
		logic tempRange;
		logic [1:0] comparatorGain;
		logic [1:0] converterGain;
	} fixed_ref_type;

endpackage

// [tb/adc_conversion_control_properties.sv]
`timescale 1ns/1ps
module adc_conversion_control_properties (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [adc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	input wire logic [6:0] channelConnect,
	input wire logic refFromPin,
	input wire logic tempEnable,
	input wire logic tempHighRange,
	input wire logic irqRequest,
	input wire logic wakeRequest,
	input wire logic vectorRequest
);
	import adc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// routing and analog controls
	chk_chan_single: assert property ($onehot0(channelConnect))
		else $error("several sources connected");
	chk_chan_temp: assert property (regWrite && regAddr == OFF_CTRL_ZERO
		&& regWrData[6:2] == CHAN_TEMP |-> ##2 channelConnect == 7'h10)
		else $error("temp code not routed");
	chk_temp_on: assert property (regWrite && regAddr == OFF_FIXED_REF_TEMP
		|-> ##2 tempEnable == $past(regWrData[5], 2))
		else $error("sensor enable wrong");
	chk_temp_range: assert property (regWrite && regAddr == OFF_FIXED_REF_TEMP
		|-> ##2 tempHighRange == $past(regWrData[4], 2))
		else $error("sensor range wrong");
	chk_ref_pin: assert property (regWrite && regAddr == OFF_CTRL_ONE
		|-> ##2 refFromPin == ($past(regWrData[1:0], 2) == PREF_PIN))
		else $error("reference select wrong");
	// request gating, sticky request and idle read data
	chk_wake_gate: assert property (wakeRequest |-> irqRequest)
		else $error("wake without request");
	chk_vector_gate: assert property (vectorRequest |-> irqRequest)
		else $error("vector without request");
	chk_flag_sticky: assert property ($fell(irqRequest)
		|-> $past(regWrite && regAddr == OFF_IRQ_CONTROL, 2))
		else $error("request dropped by itself");
	chk_read_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
		else $error("read data outside its cycle");
	// main scenarios
	cover property ($rose(irqRequest));
	cover property (wakeRequest);
	cover property (vectorRequest);
endmodule

bind adc_conversion_control adc_conversion_control_properties i_adc_conversion_control_properties (
	.clock, .reset_n, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
	.channelConnect, .refFromPin, .tempEnable, .tempHighRange, .irqRequest,
	.wakeRequest, .vectorRequest
);

// [tb/analog_front_model.sv]
`timescale 1ns/1ps
module analog_front_model (
	input wire logic clock,
	input wire logic [9:0] trialCode,
	input wire logic [6:0] channelConnect,
	input wire logic [9:0] pinLevel,
	output logic compareHigh,
	output logic rcTick
);
	localparam logic [9:0] TEMP_LEVEL = 10'h155;
	localparam logic [9:0] REF_LEVEL = 10'h3c0;
	logic [9:0] source;
	logic [1:0] rcCount = 2'h0;
	// level on the hold node, inverted pin level when nothing is routed
	always_comb begin
		case (channelConnect)
			7'h10: source = TEMP_LEVEL;
			7'h20, 7'h40: source = REF_LEVEL;
			7'h00: source = ~pinLevel;
			default: source = pinLevel;
		endcase
	end
	assign compareHigh = source >= trialCode;
	// free running rc oscillator, one tick every third clock
	always_ff @(posedge clock) begin
		rcCount <= (rcCount == 2'h2) ? 2'h0 : rcCount + 2'h1;
	end
	assign rcTick = rcCount == 2'h2;
endmodule

// [tb/test_adc_conversion_control.sv]
`timescale 1ns/1ps
module test_adc_conversion_control;
	import adc_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [7:0] regWrData = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic sleepMode = 1'b0;
	logic [9:0] pinLevel = 10'h2a5;
	logic [7:0] regRdData;
	logic [7:0] rdVal;
	logic [9:0] trialCode;
	logic [6:0] channelConnect;
	logic [1:0] converterRefGain, comparatorRefGain;
	logic rcTick, compareHigh, sampleHold, refFromPin, tempEnable, tempHighRange;
	logic fixedRefEnable, converterOn, irqRequest, wakeRequest, vectorRequest;
	int error_cnt = 0;
	int checks = 0;

	adc_conversion_control i_adc_conversion_control (.clock, .reset_n, .regAddr,
		.regWrData, .regWrite, .regRead, .regRdData, .rcTick, .sleepMode, .compareHigh,
		.trialCode, .sampleHold, .channelConnect, .refFromPin, .tempEnable, .tempHighRange,
		.fixedRefEnable, .converterRefGain, .comparatorRefGain, .converterOn, .irqRequest,
		.wakeRequest, .vectorRequest);
	analog_front_model i_analog_front_model (.clock, .trialCode, .channelConnect,
		.pinLevel, .compareHigh, .rcTick);

	// 25 MHz clock
	initial begin
		forever #20 clock = ~clock;
	end

	task automatic check(string what, logic [9:0] seen, logic [9:0] expected);
		checks++;
		if (seen !== expected) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, expected, seen);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// bus cycles, entered just after a rising edge
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic rd(logic [2:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 rdVal = regRdData;
	endtask

	// bounded wait for a request line
	task automatic await(ref logic sig, output int n);
		n = 0;
		while (sig !== 1'b1) begin
			@(posedge clock);
			#1 n++;
			if (n > 3000) begin
				error_cnt++;
				finish_test();
			end
		end
	endtask

	task automatic test_regs();
		for (int a = 0; a < 8; a++) begin
			rd(3'(a));
			check("reset value", 10'(rdVal), 10'h000);
		end
		wr(3'h7, 8'hff);
		rd(3'h7);
		check("unmapped", 10'(rdVal), 10'h000);
		wr(OFF_FIXED_REF_TEMP, 8'hbd);
		wr(OFF_CTRL_ONE, 8'h02);
		rd(OFF_FIXED_REF_TEMP);
		check("fixed ref reg", 10'(rdVal), 10'h0fd);
		check("ref enable", 10'(fixedRefEnable), 10'h001);
		check("cmp gain", 10'(comparatorRefGain), 10'h003);
		check("adc gain", 10'(converterRefGain), 10'h001);
		check("temp enable", 10'(tempEnable), 10'h001);
		check("temp range", 10'(tempHighRange), 10'h001);
		check("ref pin", 10'(refFromPin), 10'h001);
		wr(OFF_FIXED_REF_TEMP, 8'h20);
		wr(OFF_CTRL_ONE, 8'h00);
		rd(OFF_CTRL_ONE);
		check("low range", 10'(tempHighRange), 10'h000);
		check("ref supply", 10'(refFromPin), 10'h000);
		check("ref off", 10'(fixedRefEnable), 10'h000);
		check("adc gain off", 10'(converterRefGain), 10'h000);
	endtask

	task automatic test_channels();
		logic [4:0] codes[8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e, 5'h1f, 5'h04};
		logic [6:0] hot[8] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h00};
		for (int i = 0; i < 8; i++) begin
			wr(OFF_CTRL_ZERO, {1'b0, codes[i], 2'b00});
			repeat (2) @(posedge clock);
			#1 check("channel", 10'(channelConnect), 10'(hot[i]));
		end
	endtask

	// one conversion on a channel; half is clocks per half period, 0 for rc
	task automatic convert(logic [2:0] sel, logic just, int half, logic [4:0] chan,
		int settle, logic [9:0] level);
		int n;
		logic [15:0] exp;
		wr(OFF_CTRL_ONE, {just, sel, 4'h0});
		wr(OFF_IRQ_CONTROL, 8'h02);
		wr(OFF_CTRL_ZERO, {1'b0, chan, 2'b01});
		repeat (settle) @(posedge clock);
		wr(OFF_CTRL_ZERO, {1'b0, chan, 2'b11});
		await(irqRequest, n);
		if (half > 0) check("conv clocks", 10'(n), 10'(23 * half + 1));
		exp = just ? {6'h00, level} : {level, 6'h00};
		rd(OFF_RESULT_HIGH);
		check("result high", 10'(rdVal), 10'(exp[15:8]));
		rd(OFF_RESULT_LOW);
		check("result low", 10'(rdVal), 10'(exp[7:0]));
		rd(OFF_CTRL_ZERO);
		check("go cleared", 10'(rdVal), 10'({1'b0, chan, 2'b01}));
		check("converter on", 10'(converterOn), 10'h001);
		rd(OFF_IRQ_CONTROL);
		check("done flag", 10'(rdVal), 10'h003);
	endtask

	task automatic test_sleep();
		int n;
		wr(OFF_CTRL_ONE, 8'h80);
		sleepMode <= 1'b1;
		wr(OFF_CTRL_ZERO, 8'h03);
		rd(OFF_CTRL_ZERO);
		check("no sleep start", 10'(rdVal), 10'h001);
		wr(OFF_CTRL_ONE, 8'h30);
		wr(OFF_IRQ_CONTROL, 8'h06);
		wr(OFF_CTRL_ZERO, 8'h03);
		await(wakeRequest, n);
		check("wake", 10'(wakeRequest), 10'h001);
		check("inline", 10'(vectorRequest), 10'h000);
		sleepMode <= 1'b0;
		wr(OFF_IRQ_CONTROL, 8'h0f);
		rd(OFF_IRQ_CONTROL);
		check("vector", 10'(vectorRequest), 10'h001);
		wr(OFF_IRQ_CONTROL, 8'h0e);
		rd(OFF_IRQ_CONTROL);
		check("cleared", 10'(irqRequest), 10'h000);
		// software abort mid conversion
		wr(OFF_CTRL_ONE, 8'h60);
		wr(OFF_CTRL_ZERO, 8'h03);
		rd(OFF_CTRL_ZERO);
		check("busy", 10'(rdVal), 10'h003);
		repeat (100) @(posedge clock);
		#1 check("holding", 10'(sampleHold), 10'h001);
		wr(OFF_CTRL_ZERO, 8'h01);
		rd(OFF_IRQ_CONTROL);
		check("abort no flag", 10'(rdVal), 10'h00e);
		check("released", 10'(sampleHold), 10'h000);
		wr(OFF_CTRL_ZERO, 8'h03);
		sleepMode <= 1'b1;
		rd(OFF_CTRL_ZERO);
		check("sleep abort", 10'(rdVal), 10'h001);
		sleepMode <= 1'b0;
		rd(OFF_IRQ_CONTROL);
		check("sleep no flag", 10'(rdVal), 10'h00e);
	endtask

	// main sequence
	initial begin
		logic [2:0] sels[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
		logic [9:0] lv[8] = '{10'h2a5, 10'h000, 10'h3ff, 10'h155, 10'h001, 10'h200,
			10'h0f3, 10'h30c};
		int halves[8] = '{1, 2, 4, 8, 16, 32, 0, 0};
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		test_regs();
		test_channels();
		for (int i = 0; i < 8; i++) begin
			pinLevel <= lv[i];
			convert(sels[i], i[0], halves[i], 5'h00, 20, lv[i]);
		end
		// two sensor conversions spaced by the settle time
		repeat (2) convert(CLK_DIV2, 1'b1, 1, CHAN_TEMP, TEMP_SETTLE_CYCLES,
			i_analog_front_model.TEMP_LEVEL);
		test_sleep();
		finish_test();
	end
endmodule
